// ### usc_top.sv
// Serial port control registers, transmitter, shift mode and interrupt logic
`timescale 1ns/1ps
`default_nettype none
`include "usc_map.svh"
module usc_top (
    input  wire logic             mclk_i,     // Clock, 125 MHz
    input  wire logic             rst_n_i,    // Sync reset, active low
    input  wire usc_pkg::usc_byte_t addr_i,   // Register address
    input  wire usc_pkg::usc_byte_t wdata_i,  // Write data
    input  wire logic             wr_i,       // Byte write strobe
    input  wire logic             rd_i,       // Read strobe
    input  wire logic             bitwr_i,    // Single-bit write strobe
    input  wire logic [2:0]       bitsel_i,   // Bit index for bit write
    input  wire logic             bitval_i,   // Bit value for bit write
    output var  usc_pkg::usc_byte_t rdata_o,  // Read data, cycle after read
    output logic                  txd_o,      // Serial out, or shift clock in mode 0
    input  wire logic             rxd_i,      // Serial in pin level
    output logic                  rxd_o,      // Mode 0 data out
    output logic                  rxd_oe_n_o, // Mode 0 drive enable, low drives
    output logic                  irq_o       // Interrupt level
);
    import usc_pkg::*;

    // ==========================================================
    // State
    logic       sm0_r, sm1_r, mpe_r, ren_r, tb8_r, rb8_r, ti_r, ri_r, fe_r;
    usc_byte_t  rbuf_r, brl_r, station_address_r, mask_r, imsk_r, rdata_r, brg_r;
    logic [1:0] cfg_r;
    logic [2:0] ist_r;
    logic       rs1_r, rs2_r, rs3_r, rxf_r;
    logic [1:0] div_r;
    logic       half_r;
    usc_tx_st_t tx_st_r;
    logic [10:0] tx_sh_r;
    logic [3:0] tx_sub_r, tx_bit_r;
    logic       ph_r, sy_rx_r;
    logic       txd_r, rxd_r, oe_n_r;

    logic       mode0, mode2, nine, fce, div_en, tick16;
    logic       sc_we, buf_wr, sy_go, sy_end, ti_async, ti_evt, ri_evt, rx_acc, fe_evt;
    logic       sel_bit, given_m, bcast_m, mp_ok;
    logic [3:0] tx_last;
    usc_byte_t  sc_cur, sc_new, bmask, bcast, rx_byte;

    usc_rx_if   rx_if ();

    assign mode0   = !sm0_r && !sm1_r;
    assign mode2   = sm0_r && !sm1_r;
    assign nine    = sm0_r;
    assign fce     = cfg_r[`USC_CFG_FCE];
    assign tx_last = nine ? `USC_LAST9 : `USC_LAST8;

    // ==========================================================
    // Pin synchroniser: a change counts once stages two and three agree
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rs1_r <= 1'b1;
            rs2_r <= 1'b1;
            rs3_r <= 1'b1;
            rxf_r <= 1'b1;
        end else begin
            rs1_r <= rxd_i;
            rs2_r <= rs1_r;
            rs3_r <= rs2_r;
            if (rs2_r == rs3_r) begin
                rxf_r <= rs3_r;
            end
        end
    end

    // ==========================================================
    // Rate generation: mode 0 half-bit enable, async 16x tick
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            div_r  <= 2'h0;
            half_r <= 1'b0;
            brg_r  <= 8'h00;
        end else begin
            div_r  <= div_en ? 2'h0 : div_r + 2'h1;
            half_r <= ~half_r;
            // Reload on overflow sets the variable rate of modes 1 and 3
            brg_r  <= (brg_r == `USC_BRG_TOP) ? brl_r : brg_r + 8'h01;
        end
    end
    assign div_en = (div_r == `USC_DIV0_LAST);
    // Mode 2 bit time is 32 clocks, or 16 with the double-rate bit
    assign tick16 = mode2 ? (cfg_r[`USC_CFG_DBL] | half_r)
                          : (brg_r == `USC_BRG_TOP);

    // ==========================================================
    // Receiver hookup and address filter
    assign rx_if.tick16 = tick16;
    assign rx_if.nine   = nine;
    assign rx_if.en     = ren_r && !mode0;
    assign rx_if.line   = rxf_r;

    usc_rx u_rx (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .rx      (rx_if.rx)
    );

    assign bcast   = station_address_r | mask_r;
    assign given_m = ((rx_if.data ^ station_address_r) & mask_r) == 8'h00;
    assign bcast_m = (rx_if.data & bcast) == bcast;
    // In mode 1 the stop bit stands in for the ninth bit
    assign sel_bit = nine ? rx_if.bit9 : rx_if.stop_ok;
    assign mp_ok   = !mpe_r || (sel_bit && (given_m || bcast_m));
    assign rx_acc  = rx_if.done && mp_ok;
    assign fe_evt  = rx_if.done && fce && !rx_if.stop_ok;

    // ==========================================================
    // Transmitter and mode 0 shifter share one sequencer
    assign buf_wr   = wr_i && addr_i == `USC_ADDR_BUF;
    assign sy_go    = mode0 && ren_r && !ri_r && !buf_wr;
    assign sy_end   = tx_st_r == TX_SYNC && div_en && ph_r && tx_bit_r == `USC_SYNC_LAST;
    assign ti_async = tx_st_r == TX_ASYNC && tick16 && tx_sub_r == `USC_SUB_LAST
                      && tx_bit_r == tx_last - 4'h1;
    assign ti_evt   = ti_async || (sy_end && !sy_rx_r);
    assign ri_evt   = rx_acc || (sy_end && sy_rx_r);
    assign rx_byte  = {rxf_r, tx_sh_r[7:1]};

    // Writes while a frame is in flight are dropped
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            tx_st_r  <= TX_IDLE;
            tx_sh_r  <= 11'h7FF;
            tx_sub_r <= 4'h0;
            tx_bit_r <= 4'h0;
            ph_r     <= 1'b0;
            sy_rx_r  <= 1'b0;
        end else begin
            case (tx_st_r)
                TX_IDLE: begin
                    tx_sub_r <= 4'h0;
                    tx_bit_r <= 4'h0;
                    ph_r     <= 1'b0;
                    if (buf_wr) begin
                        sy_rx_r <= 1'b0;
                        if (mode0) begin
                            tx_sh_r <= {3'h7, wdata_i};
                            tx_st_r <= TX_SYNC;
                        end else begin
                            tx_sh_r <= {1'b1, nine ? tb8_r : 1'b1, wdata_i, 1'b0};
                            tx_st_r <= TX_ASYNC;
                        end
                    end else if (sy_go) begin
                        sy_rx_r <= 1'b1;
                        tx_st_r <= TX_SYNC;
                    end
                end
                TX_ASYNC: if (tick16) begin
                    tx_sub_r <= tx_sub_r + 4'h1;
                    if (tx_sub_r == `USC_SUB_LAST) begin
                        tx_sh_r  <= {1'b1, tx_sh_r[10:1]};
                        tx_bit_r <= tx_bit_r + 4'h1;
                        if (tx_bit_r == tx_last) begin
                            tx_st_r <= TX_IDLE;
                        end
                    end
                end
                default: if (div_en) begin
                    ph_r <= ~ph_r;
                    // Sample at the end of the high phase, data has long settled
                    if (ph_r) begin
                        tx_sh_r  <= sy_rx_r ? {tx_sh_r[10:8], rx_byte}
                                            : {1'b1, tx_sh_r[10:1]};
                        tx_bit_r <= tx_bit_r + 4'h1;
                        if (tx_bit_r == `USC_SYNC_LAST) begin
                            tx_st_r <= TX_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Pin drivers, idle high and released
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            txd_r  <= 1'b1;
            rxd_r  <= 1'b1;
            oe_n_r <= 1'b1;
        end else begin
            case (tx_st_r)
                TX_ASYNC: begin
                    txd_r  <= tx_sh_r[0];
                    rxd_r  <= 1'b1;
                    oe_n_r <= 1'b1;
                end
                TX_SYNC: begin
                    txd_r  <= ph_r;
                    rxd_r  <= tx_sh_r[0];
                    oe_n_r <= sy_rx_r;
                end
                default: begin
                    txd_r  <= 1'b1;
                    rxd_r  <= 1'b1;
                    oe_n_r <= 1'b1;
                end
            endcase
        end
    end
    assign txd_o      = txd_r;
    assign rxd_o      = rxd_r;
    assign rxd_oe_n_o = oe_n_r;

    // ==========================================================
    // Serial control: byte or single-bit writes, hardware sets win
    assign sc_cur = {fce ? fe_r : sm0_r, sm1_r, mpe_r, ren_r, tb8_r, rb8_r, ti_r, ri_r};
    assign bmask  = 8'h01 << bitsel_i;
    assign sc_we  = (wr_i || bitwr_i) && addr_i == `USC_ADDR_CTRL;
    assign sc_new = bitwr_i ? ((sc_cur & ~bmask) | (bitval_i ? bmask : 8'h00)) : wdata_i;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            {sm0_r, sm1_r, mpe_r, ren_r, tb8_r} <= 5'h00;
        end else if (sc_we) begin
            if (!fce) begin
                sm0_r <= sc_new[`USC_SC_SM0];
            end
            sm1_r <= sc_new[`USC_SC_SM1];
            mpe_r <= sc_new[`USC_SC_MPE];
            ren_r <= sc_new[`USC_SC_REN];
            tb8_r <= sc_new[`USC_SC_TB8];
        end
    end

    // Flags: event in the clearing cycle is kept
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            {rb8_r, ti_r, ri_r, fe_r} <= 4'h0;
        end else begin
            if (rx_acc) begin
                rb8_r <= sel_bit;
            end else if (sc_we) begin
                rb8_r <= sc_new[`USC_SC_RB8];
            end
            ti_r <= ti_evt || (sc_we ? sc_new[`USC_SC_TI] : ti_r);
            ri_r <= ri_evt || (sc_we ? sc_new[`USC_SC_RI] : ri_r);
            // Good frames never clear it; only software or reset
            fe_r <= fe_evt || ((sc_we && fce) ? sc_new[`USC_SC_SM0] : fe_r);
        end
    end

    // Receive buffer carries no reset value
    always_ff @(posedge mclk_i) begin
        if (rx_acc) begin
            rbuf_r <= rx_if.data;
        end else if (sy_end && sy_rx_r) begin
            rbuf_r <= rx_byte;
        end
    end

    // Plain byte registers
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            brl_r   <= `USC_BYTE_RST;
            station_address_r <= `USC_BYTE_RST;
            mask_r  <= `USC_BYTE_RST;
            imsk_r  <= `USC_BYTE_RST;
            cfg_r   <= 2'h0;
        end else if (wr_i) begin
            if (addr_i == `USC_ADDR_BRL) begin
                brl_r <= wdata_i;
            end else if (addr_i == `USC_ADDR_STATION_ADDRESS) begin
                station_address_r <= wdata_i;
            end else if (addr_i == `USC_ADDR_MASK) begin
                mask_r <= wdata_i;
            end else if (addr_i == `USC_ADDR_IMSK) begin
                imsk_r <= wdata_i;
            end else if (addr_i == `USC_ADDR_CFG) begin
                cfg_r <= wdata_i[1:0];
            end
        end
    end

    // ==========================================================
    // Interrupt status, cleared by reading it
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ist_r <= 3'h0;
        end else begin
            ist_r <= ((rd_i && addr_i == `USC_ADDR_IST) ? 3'h0 : ist_r)
                     | {fe_evt, ti_evt, ri_evt};
        end
    end
    assign irq_o = |(ist_r & imsk_r[2:0]);

    // Read port; unmapped addresses read zero
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rdata_r <= 8'h00;
        end else if (rd_i) begin
            if (addr_i == `USC_ADDR_CTRL) begin
                rdata_r <= sc_cur;
            end else if (addr_i == `USC_ADDR_BUF) begin
                rdata_r <= rbuf_r;
            end else if (addr_i == `USC_ADDR_BRL) begin
                rdata_r <= brl_r;
            end else if (addr_i == `USC_ADDR_CFG) begin
                rdata_r <= {6'h00, cfg_r};
            end else if (addr_i == `USC_ADDR_IST) begin
                rdata_r <= {5'h00, ist_r};
            end else if (addr_i == `USC_ADDR_IMSK) begin
                rdata_r <= imsk_r;
            end else if (addr_i == `USC_ADDR_STATION_ADDRESS) begin
                rdata_r <= station_address_r;
            end else if (addr_i == `USC_ADDR_MASK) begin
                rdata_r <= mask_r;
            end else begin
                rdata_r <= 8'h00;
            end
        end
    end
    assign rdata_o = rdata_r;

    // ==========================================================
    // Checks
    AST_RESET_VAL: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !$past(rst_n_i) |-> sc_cur == 8'h00 && station_address_r == 8'h00 && mask_r == 8'h00
        && brl_r == 8'h00)
        else $error("register not zero after reset");
    AST_DIV6: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        div_en |=> !div_en ##1 !div_en ##1 div_en)
        else $error("mode 0 half period not three clocks");
    AST_NINTH_TX: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (buf_wr && tx_st_r == TX_IDLE && nine) |=> tx_sh_r[9] == $past(tb8_r))
        else $error("ninth transmit bit not loaded");
    AST_RB8: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (rx_acc && nine) |=> rb8_r == $past(rx_if.bit9))
        else $error("received ninth bit not stored");
    AST_REN: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        rx_if.done |-> $past(ren_r, 2))
        else $error("frame received while disabled");
    AST_MPE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (rx_if.done && mpe_r && nine && !rx_if.bit9) |-> !ri_evt)
        else $error("data frame passed the filter");
    AST_TI_STOP: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (tx_st_r == TX_ASYNC && $rose(ti_r)) |-> tx_bit_r == tx_last)
        else $error("transmit done not at stop bit");
    AST_FE_STICKY: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (fe_r && !(sc_we && fce)) |=> fe_r)
        else $error("framing error cleared by hardware");
    AST_ADDR: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (rx_acc && mpe_r) |-> (given_m || bcast_m) && sel_bit)
        else $error("unaddressed frame accepted");
    AST_START: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (buf_wr && tx_st_r == TX_IDLE) |=> tx_st_r != TX_IDLE ##1 tx_st_r != TX_IDLE)
        else $error("buffer write did not start a frame");

    COV_TX9: cover property (@(posedge mclk_i) disable iff (!rst_n_i) ti_async && nine);
    COV_RX_MP: cover property (@(posedge mclk_i) disable iff (!rst_n_i) rx_acc && mpe_r);
    COV_FE: cover property (@(posedge mclk_i) disable iff (!rst_n_i) fe_evt);
    COV_SYNC_RX: cover property (@(posedge mclk_i) disable iff (!rst_n_i) sy_end && sy_rx_r);
endmodule
`default_nettype wire

// ### usc_map.svh
// Register offsets, field positions, reset values and counts of the serial control block
// Functional notes
// - Two mode bits pick shift register /6, 8-bit variable, 9-bit /32or/16, 9-bit variable.
// - In modes 2 and 3 the ninth transmitted bit equals the ninth-transmit-bit control.
// - In 9-bit modes the ninth received bit is loaded into the received-ninth-bit flag.
// - Frames are received only while receive enable is set.
// - Serial control resets to zero and accepts single-bit writes as well as bytes.
// - Station address mask resets to zero, making every address bit don't-care.
// - Station address resets to zero and is byte access only.
// - Serial buffer has no reset value; nothing relies on it before a load.
// - The 8-bit baud reload register feeds the internal baud generator, reset zero.
// - With framing check on, a bad stop bit sets a sticky framing error flag.
// - Own address is station address with mask-zero bits treated as don't-care.
// - Broadcast address is address OR mask, zero bits don't-care.
// - In modes 2/3 with filtering on, receive done rises only if ninth bit is 1.
`ifndef USC_MAP_SVH
`define USC_MAP_SVH

// ==========================================================
// Register offsets
`define USC_ADDR_CTRL   8'h98
`define USC_ADDR_BUF    8'h99
`define USC_ADDR_BRL    8'h9A
`define USC_ADDR_CFG    8'h9B
`define USC_ADDR_IST    8'h9C
`define USC_ADDR_IMSK   8'h9D
`define USC_ADDR_STATION_ADDRESS  8'hA9
`define USC_ADDR_MASK   8'hB9

// ==========================================================
// Serial control fields
`define USC_SC_RI       0
`define USC_SC_TI       1
`define USC_SC_RB8      2
`define USC_SC_TB8      3
`define USC_SC_REN      4
`define USC_SC_MPE      5
`define USC_SC_SM1      6
`define USC_SC_SM0      7
`define USC_SC_RST      8'h00

// Configuration and interrupt fields
`define USC_CFG_FCE     0
`define USC_CFG_DBL     1
`define USC_IST_RX      0
`define USC_IST_TX      1
`define USC_IST_FE      2
`define USC_BYTE_RST    8'h00

// ==========================================================
// Counts
`define USC_DIV0_LAST   2'h2
`define USC_SUB_LAST    4'hF
`define USC_SUB_MID     4'h7
`define USC_BRG_TOP     8'hFF
`define USC_SYNC_LAST   4'h7
`define USC_LAST8       4'h9
`define USC_LAST9       4'hA

`endif

// ### usc_pkg.sv
// Types shared by the serial control block
package usc_pkg;
    typedef logic [7:0] usc_byte_t;
    typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SYNC} usc_tx_st_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} usc_rx_st_t;
endpackage

// ### usc_rx_if.sv
// Carrier between the control logic and the asynchronous receiver
`timescale 1ns/1ps
`default_nettype none
interface usc_rx_if;
    logic       tick16;
    logic       nine;
    logic       en;
    logic       line;
    logic       done;
    logic [7:0] data;
    logic       bit9;
    logic       stop_ok;
    modport rx  (input tick16, nine, en, line, output done, data, bit9, stop_ok);
    modport ctl (output tick16, nine, en, line, input done, data, bit9, stop_ok);
endinterface
`default_nettype wire

// ### usc_rx.sv
// Asynchronous frame receiver with 16x oversampling
`timescale 1ns/1ps
`default_nettype none
`include "usc_map.svh"
module usc_rx (
    input wire logic mclk_i,   // Clock
    input wire logic rst_n_i,  // Sync reset, active low
    usc_rx_if.rx     rx        // Link to control logic
);
    import usc_pkg::*;

    usc_rx_st_t st_r;
    logic [3:0] sub_r;
    logic [3:0] bit_r;
    logic [8:0] sh_r;
    logic [3:0] last_w;

    assign last_w = rx.nine ? 4'h8 : 4'h7;

    // ==========================================================
    // Frame state; disabling drops any frame in flight
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            st_r  <= RX_IDLE;
            sub_r <= 4'h0;
            bit_r <= 4'h0;
        end else if (!rx.en) begin
            st_r <= RX_IDLE;
        end else begin
            case (st_r)
                RX_IDLE: begin
                    sub_r <= 4'h0;
                    bit_r <= 4'h0;
                    if (!rx.line) begin
                        st_r <= RX_START;
                    end
                end
                RX_START: if (rx.tick16) begin
                    sub_r <= sub_r + 4'h1;
                    // A glitch shorter than half a bit is not a start bit
                    if (sub_r == `USC_SUB_MID) begin
                        sub_r <= 4'h0;
                        st_r  <= rx.line ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: if (rx.tick16) begin
                    sub_r <= sub_r + 4'h1;
                    if (sub_r == `USC_SUB_LAST) begin
                        bit_r <= bit_r + 4'h1;
                        if (bit_r == last_w) begin
                            st_r <= RX_STOP;
                        end
                    end
                end
                default: if (rx.tick16) begin
                    sub_r <= sub_r + 4'h1;
                    if (sub_r == `USC_SUB_LAST) begin
                        st_r <= RX_IDLE;
                    end
                end
            endcase
        end
    end

    // Data shifter, LSB first
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            sh_r <= 9'h000;
        end else if (st_r == RX_DATA && rx.tick16 && sub_r == `USC_SUB_LAST) begin
            sh_r <= {rx.line, sh_r[8:1]};
        end
    end

    // Result registers, done is a one-cycle pulse at mid stop bit
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rx.done    <= 1'b0;
            rx.data    <= 8'h00;
            rx.bit9    <= 1'b0;
            rx.stop_ok <= 1'b0;
        end else begin
            rx.done <= rx.en && st_r == RX_STOP && rx.tick16 && sub_r == `USC_SUB_LAST;
            if (st_r == RX_STOP && rx.tick16 && sub_r == `USC_SUB_LAST) begin
                rx.data    <= rx.nine ? sh_r[7:0] : sh_r[8:1];
                rx.bit9    <= sh_r[8];
                rx.stop_ok <= rx.line;
            end
        end
    end

    AST_RX_DONE_STOP: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        rx.done |-> $past(st_r) == RX_STOP)
        else $error("receive done outside stop bit");
endmodule
`default_nettype wire

// ### usc_node.sv
// Remote serial node model facing the serial port lines
`timescale 1ns/1ps
`default_nettype none
module usc_node (
    input  wire logic mclk_i, // Clock
    input  wire logic txd_i,  // Line from the port
    output var  logic rxd_o   // Line to the port
);
    // ==========================================
    // Line idles high, as a pulled-up link would
    initial rxd_o = 1'b1;
    // Frame: start, 8 data LSB first, ninth bit, stop; bt clocks a bit
    task automatic send(input logic [8:0] d, input logic stp, input int bt);
        logic [10:0] f;
        f = {stp, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            rxd_o <= f[i];
            repeat (bt) @(posedge mclk_i);
        end
        rxd_o <= 1'b1;
        repeat (8) @(posedge mclk_i);
    endtask
    // Mid-bit capture of a 9-bit frame; bounded wait for the start bit
    task automatic grab(input int bt, output logic [8:0] d);
        int n;
        n = 0;
        while (txd_i !== 1'b0 && n < 4000) begin
            @(posedge mclk_i);
            n++;
        end
        repeat (bt / 2) @(posedge mclk_i);
        for (int i = 0; i < 9; i++) begin
            repeat (bt) @(posedge mclk_i);
            d[i] = txd_i;
        end
    endtask
endmodule
`default_nettype wire

// ### uart_control_registers_test.sv
// Self-checking bench for the serial control registers
`timescale 1ns/1ps
`default_nettype none
module uart_control_registers_test;
    import usc_pkg::*;
    // ==========================================
    // Bench state; the pin merges both drivers
    logic        mclk_i = 1'b0;
    logic        rst_n  = 1'b0;
    usc_byte_t   addr = 8'h00, wdata = 8'h00, rdata, v, d;
    logic        wr = 1'b0, rd = 1'b0, bwr = 1'b0, bval = 1'b0;
    logic [2:0]  bsel = 3'h0;
    logic        txd, rxo, oe_n, irq, ntx, pin;
    logic [8:0]  got;
    logic [15:0] lfsr = 16'hE814;
    int          fail_count = 0, checks = 0;
    assign pin = oe_n ? ntx : rxo;
    always #4 mclk_i = ~mclk_i;
    usc_node node (.mclk_i(mclk_i), .txd_i(txd), .rxd_o(ntx));
    usc_top dut (.mclk_i(mclk_i), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .bitwr_i(bwr), .bitsel_i(bsel), .bitval_i(bval),
        .rdata_o(rdata), .txd_o(txd), .rxd_i(pin), .rxd_o(rxo), .rxd_oe_n_o(oe_n),
        .irq_o(irq));
    // Random source, fixed start so runs repeat
    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input usc_byte_t g, input usc_byte_t e);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic wreg(input usc_byte_t a, input usc_byte_t x);
        addr <= a;
        wdata <= x;
        wr <= 1'b1;
        @(posedge mclk_i);
        wr <= 1'b0;
        @(posedge mclk_i);
    endtask
    // Read data stand from the cycle after the strobe until the next read
    task automatic rreg(input usc_byte_t a, output usc_byte_t x);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk_i);
        rd <= 1'b0;
        #1 x = rdata;
        @(posedge mclk_i);
    endtask
    // Read one register and compare the masked bits
    task automatic rchk(input usc_byte_t a, input usc_byte_t m, input usc_byte_t e);
        rreg(a, v);
        chk(v & m, e);
    endtask
    task automatic bitw(input usc_byte_t a, input logic [2:0] i);
        addr <= a;
        bsel <= i;
        bval <= 1'b1;
        bwr <= 1'b1;
        @(posedge mclk_i);
        bwr <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic end_sim();
        if (fail_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Watchdog: all frames fit well inside this span
    initial begin
        repeat (20000) @(posedge mclk_i);
        fail_count++;
        end_sim();
    end
    // ==========================================
    // Main sequence
    initial begin
        repeat (20) @(posedge mclk_i);
        rst_n <= 1'b1;
        @(posedge mclk_i);
        rchk(8'h98, 8'hFF, 8'h00);
        rchk(8'h9A, 8'hFF, 8'h00);
        rchk(8'hA9, 8'hFF, 8'h00);
        rchk(8'hB9, 8'hFF, 8'h00);
        // Random byte into the reload register, then one to an unmapped address
        lfsr = nxt(lfsr);
        wreg(8'h9A, lfsr[7:0]);
        rchk(8'h9A, 8'hFF, lfsr[7:0]);
        // Two clocks a tick from here on, long before mode 3 needs it
        wreg(8'h9A, 8'hFE);
        lfsr = nxt(lfsr);
        wreg(8'hC8, lfsr[7:0]);
        rchk(8'hC8, 8'hFF, 8'h00);
        rchk(8'h00, 8'hFF, 8'h00);
        wreg(8'hA9, 8'h00);
        bitw(8'hA9, 3'h3);
        rchk(8'hA9, 8'hFF, 8'h00);
        wreg(8'hB9, 8'h00);
        // Ninth-bit control, as receive enable would start a mode 0 receive here
        bitw(8'h98, 3'h3);
        rchk(8'h98, 8'hFF, 8'h08);
        // Mode 2 at double rate: 16 clocks a bit, ninth bit set
        wreg(8'h9B, 8'h02);
        wreg(8'h9D, 8'h07);
        wreg(8'h98, 8'h98);
        lfsr = nxt(lfsr);
        d = lfsr[7:0];
        wreg(8'h99, d);
        node.grab(16, got);
        chk(got[7:0], d);
        chk({7'h00, got[8]}, 8'h01);
        repeat (16) @(posedge mclk_i);
        rchk(8'h98, 8'hFF, 8'h9A);
        chk({7'h00, irq}, 8'h01);
        rchk(8'h9C, 8'hFF, 8'h02);
        chk({7'h00, irq}, 8'h00);
        // Receive with the interrupt masked, then unmasked
        wreg(8'h9D, 8'h00);
        wreg(8'h98, 8'h90);
        node.send({1'b1, ~d}, 1'b1, 16);
        rchk(8'h99, 8'hFF, ~d);
        rchk(8'h98, 8'hFF, 8'h95);
        chk({7'h00, irq}, 8'h00);
        wreg(8'h9D, 8'h01);
        chk({7'h00, irq}, 8'h01);
        // Filter on: ninth bit 0 ignored; given and broadcast addresses taken
        wreg(8'hA9, 8'h56);
        wreg(8'hB9, 8'hFC);
        wreg(8'h98, 8'hB0);
        node.send({1'b0, 8'h57}, 1'b1, 16);
        rchk(8'h98, 8'h01, 8'h00);
        node.send({1'b1, 8'h57}, 1'b1, 16);
        rchk(8'h98, 8'h05, 8'h05);
        wreg(8'h98, 8'hB0);
        node.send({1'b1, 8'h01}, 1'b1, 16);
        rchk(8'h98, 8'h01, 8'h00);
        node.send({1'b1, 8'hFE}, 1'b1, 16);
        rchk(8'h98, 8'h05, 8'h05);
        wreg(8'h98, 8'h80);
        node.send({1'b1, d}, 1'b1, 16);
        rchk(8'h98, 8'hFF, 8'h80);
        // Bad stop bit sets a sticky flag in bit 7
        wreg(8'h9B, 8'h03);
        wreg(8'h98, 8'h10);
        node.send({1'b1, d}, 1'b0, 16);
        node.send({1'b1, d}, 1'b1, 16);
        rchk(8'h98, 8'h80, 8'h80);
        // Mode 3 from the reload register: 32 clocks a bit, ninth bit clear
        wreg(8'h9B, 8'h00);
        wreg(8'h98, 8'hC0);
        lfsr = nxt(lfsr);
        wreg(8'h99, lfsr[7:0]);
        node.grab(32, got);
        chk(got[7:0], lfsr[7:0]);
        chk({7'h00, got[8]}, 8'h00);
        repeat (64) @(posedge mclk_i);
        // Mode 0 transmit: data pin driven and steady at each clock rise
        wreg(8'h98, 8'h00);
        lfsr = nxt(lfsr);
        wreg(8'h99, lfsr[7:0]);
        for (int i = 0; i < 8; i++) begin
            @(posedge txd);
            got[i] = rxo;
            chk({7'h00, oe_n}, 8'h00);
        end
        chk(got[7:0], lfsr[7:0]);
        repeat (8) @(posedge mclk_i);
        rchk(8'h98, 8'hFF, 8'h02);
        // Mode 0 receive: the released pin idles high
        wreg(8'h98, 8'h10);
        repeat (64) @(posedge mclk_i);
        rchk(8'h98, 8'hFF, 8'h11);
        rchk(8'h99, 8'hFF, 8'hFF);
        end_sim();
    end
endmodule
`default_nettype wire
